// [rtl/fepo_seq.sv]
// flash command sequencer: apb registers, launch, array control
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module fepo_seq #(
    parameter int AW = 23
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output      logic [31:0]           prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    input  wire logic [fepo_pkg::NCMD-1:0] mode_mask,
    input  wire logic                  addr_valid,
    input  wire logic                  addr_is_dflash,
    input  wire logic                  prot_any,
    input  wire logic                  prot_block,
    input  wire logic                  prot_sector,
    output      logic [AW-1:0]         tgt_addr,
    output      logic                  array_req,
    output      fepo_pkg::fepo_op_e    array_op,
    output      logic [AW-1:0]         array_addr,
    output      logic [63:0]           array_wdata,
    input  wire logic                  array_ack,
    input  wire logic                  array_blank,
    input  wire logic                  array_verr,
    input  wire logic                  array_vfatal,
    output      logic                  blk0_read_invalid,
    output      logic                  sec_release
);
    import fepo_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_BLANK, ST_OP, ST_DONE
    } fepo_st_e;

    fepo_st_e    st_r;
    logic [15:0] prm_r [NPARAM];
    logic [2:0]  idx_r;
    logic [7:0]  stat_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        pready_r;
    logic [AW-1:0] tgt_r;
    logic        req_r;
    fepo_op_e    op_r;
    logic [AW-1:0] aaddr_r;
    logic [63:0] wdata_r;
    logic        blk0_r;
    logic        rel_r;
    logic [7:0]  cmd;
    logic        wr_en;
    logic        busy;
    logic        launch;
    fepo_op_e    op_nxt;
    logic [AW-1:0] addr_nxt;

    fepo_chk_if chk_if ();

    assign cmd  = prm_r[0][15:8];
    assign busy = !stat_r[STAT_CMPL];
    // writes are dropped while busy so a running erase cannot be disturbed
    assign wr_en  = ce && psel && penable && pwrite && !busy;
    assign launch = wr_en && (paddr == ADDR_STAT)
                  && pwdata[STAT_CMPL];

    // feed the checker
    assign chk_if.cmd            = cmd;
    assign chk_if.idx            = idx_r;
    assign chk_if.word0          = prm_r[0];
    assign chk_if.word1          = prm_r[1];
    assign chk_if.mode_mask      = mode_mask;
    assign chk_if.addr_valid     = addr_valid;
    assign chk_if.addr_is_dflash = addr_is_dflash;
    assign chk_if.prot_any       = prot_any;
    assign chk_if.prot_block     = prot_block;
    assign chk_if.prot_sector    = prot_sector;

    fepo_launch_chk u_chk (
        .c (chk_if.chk)
    );

    // array operation and address chosen by the command
    always_comb begin
        addr_nxt = {prm_r[0][AW-17:0], prm_r[1]};
        unique case (cmd)
            CMD_OTP:  op_nxt = OP_PROG;
            CMD_EBLK: op_nxt = OP_ERASE_BLK;
            CMD_ESEC: op_nxt = OP_ERASE_SEC;
            default:  op_nxt = OP_ERASE_ALL;
        endcase
        if (cmd == CMD_OTP) begin
            addr_nxt = {{(AW-3){1'b0}}, prm_r[1][2:0]};
        end
    end

    // parameter array and index, written over apb when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 3'h0;
            for (int i = 0; i < NPARAM; i++) begin
                prm_r[i] <= 16'h0000;
            end
        end else if (wr_en) begin
            if (paddr == ADDR_IDX) begin
                idx_r <= pwdata[2:0];
            end
            if (paddr == ADDR_DATA && idx_r < 3'(NPARAM)) begin
                prm_r[idx_r] <= pwdata[15:0];
            end
        end
    end

    // target address toward the protection and address decoders
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_r <= '0;
        end else if (ce) begin
            tgt_r <= {prm_r[0][AW-17:0], prm_r[1]};
        end
    end

    // apb read path and error answer, prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            unique case (paddr)
                ADDR_STAT: prdata_r <= {24'h000000, stat_r};
                ADDR_IDX:  prdata_r <= {29'h0, idx_r};
                ADDR_DATA: begin
                    if (idx_r < 3'(NPARAM)) begin
                        prdata_r <= {16'h0000, prm_r[idx_r]};
                    end
                end
                default:   pslverr_r <= 1'b1;
            endcase
        end
    end

    // ready is a flop, cleared at once by the reset pin and set again on the first enabled clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else if (ce) begin
            pready_r <= 1'b1;
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r    <= ST_IDLE;
            stat_r  <= STAT_RST;
            req_r   <= 1'b0;
            op_r    <= OP_BLANK;
            aaddr_r <= '0;
            wdata_r <= 64'h0;
            blk0_r  <= 1'b0;
            rel_r   <= 1'b0;
        end else if (ce) begin
            rel_r <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    // access and protection error flags are write-one-to-clear while idle
                    if (wr_en && paddr == ADDR_STAT) begin
                        if (pwdata[STAT_ACC]) stat_r[STAT_ACC] <= 1'b0;
                        if (pwdata[STAT_PV])  stat_r[STAT_PV]  <= 1'b0;
                    end
                    if (launch) begin
                        stat_r <= 8'h00;
                        st_r   <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    stat_r[STAT_ACC] <= chk_if.acc_err;
                    stat_r[STAT_PV]  <= chk_if.pviol;
                    aaddr_r <= addr_nxt;
                    wdata_r <= {prm_r[2], prm_r[3], prm_r[4], prm_r[5]};
                    if (chk_if.acc_err || chk_if.pviol) begin
                        st_r <= ST_DONE;
                    end else if (cmd == CMD_OTP) begin
                        op_r   <= OP_BLANK;
                        req_r  <= 1'b1;
                        blk0_r <= 1'b1;
                        st_r   <= ST_BLANK;
                    end else begin
                        op_r  <= op_nxt;
                        req_r <= 1'b1;
                        st_r  <= ST_OP;
                    end
                end
                ST_BLANK: begin
                    if (array_ack) begin
                        // an all-ones phrase reads blank and may go again
                        if (array_blank) begin
                            op_r <= OP_PROG;
                            st_r <= ST_OP;
                        end else begin
                            req_r <= 1'b0;
                            stat_r[STAT_ACC] <= 1'b1;
                            st_r <= ST_DONE;
                        end
                    end
                end
                ST_OP: begin
                    if (array_ack) begin
                        req_r <= 1'b0;
                        stat_r[STAT_VF] <= array_verr;
                        stat_r[STAT_VX] <= array_vfatal;
                        if ((cmd == CMD_EALL || cmd == CMD_UNS) && !array_verr) begin
                            rel_r <= 1'b1;
                        end
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    blk0_r <= 1'b0;
                    stat_r[STAT_CMPL] <= 1'b1;
                    st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign tgt_addr          = tgt_r;
    assign array_req         = req_r;
    assign array_op          = op_r;
    assign array_addr        = aaddr_r;
    assign array_wdata       = wdata_r;
    assign blk0_read_invalid = blk0_r;
    assign sec_release       = rel_r;

    // checks on the sequencer
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_launch_clears: assert property (
        launch |=> !stat_r[STAT_CMPL] && st_r == ST_CHECK)
        else $error("launch did not clear complete");

    chk_mode_mask: assert property (
        ce && st_r == ST_CHECK && fepo_slot(cmd) < 3'h5
        && !mode_mask[fepo_slot(cmd)] |=> stat_r[STAT_ACC])
        else $error("disabled command not refused");

    chk_otp_index: assert property (
        ce && st_r == ST_CHECK && cmd == CMD_OTP
        && (idx_r != IDX_OTP || prm_r[1] > OTP_PHR_MAX) |=> stat_r[STAT_ACC] && !req_r)
        else $error("bad one-time index accepted");

    chk_skip_array: assert property (
        ce && st_r == ST_CHECK && (chk_if.acc_err || chk_if.pviol)
        |=> !req_r && st_r == ST_DONE)
        else $error("array started after launch error");

    chk_otp_used: assert property (
        ce && st_r == ST_BLANK && array_ack && !array_blank
        |=> stat_r[STAT_ACC] && !req_r && op_r == OP_BLANK)
        else $error("used phrase programmed again");

    chk_blk0_hide: assert property (
        (st_r == ST_BLANK || st_r == ST_OP) && cmd == CMD_OTP |-> blk0_read_invalid)
        else $error("block 0 readable during one-time program");

    chk_verify_flags: assert property (
        ce && st_r == ST_OP && array_ack
        |=> stat_r[STAT_VF] == $past(array_verr) && stat_r[STAT_VX] == $past(array_vfatal))
        else $error("verify flags not captured");

    chk_sec_release: assert property (
        sec_release |-> $past(st_r) == ST_OP && !$past(array_verr)
        && (cmd == CMD_EALL || cmd == CMD_UNS))
        else $error("security released without clean verify");

    chk_esec_align: assert property (
        ce && st_r == ST_CHECK && cmd == CMD_ESEC && prm_r[1][2:0] != 3'h0
        |=> stat_r[STAT_ACC])
        else $error("misaligned sector erase accepted");

    chk_eblk_prot: assert property (
        ce && st_r == ST_CHECK && cmd == CMD_EBLK && prot_block |=> stat_r[STAT_PV])
        else $error("protected block erase not flagged");

    chk_all_prot: assert property (
        ce && st_r == ST_CHECK && (cmd == CMD_EALL || cmd == CMD_UNS) && prot_any
        |=> stat_r[STAT_PV] ##1 stat_r[STAT_CMPL] || !ce)
        else $error("protected erase-all not refused");
endmodule

// [shared/fepo_pkg.sv]
// package: constants and types for the flash command sequencer
package fepo_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_STAT = 8'h00;
    localparam logic [7:0] ADDR_IDX  = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    // status bit positions
    localparam int STAT_CMPL = 7;
    localparam int STAT_ACC  = 5;
    localparam int STAT_PV   = 4;
    localparam int STAT_VF   = 1;
    localparam int STAT_VX   = 0;
    localparam logic [7:0] STAT_RST = 8'h80;
    // command codes
    localparam logic [7:0] CMD_OTP  = 8'h07;
    localparam logic [7:0] CMD_EALL = 8'h08;
    localparam logic [7:0] CMD_EBLK = 8'h09;
    localparam logic [7:0] CMD_ESEC = 8'h0a;
    localparam logic [7:0] CMD_UNS  = 8'h0b;
    // parameter index expected at launch
    localparam logic [2:0] IDX_OTP  = 3'h5;
    localparam logic [2:0] IDX_EALL = 3'h0;
    localparam logic [2:0] IDX_EBLK = 3'h1;
    localparam logic [2:0] IDX_ESEC = 3'h1;
    localparam logic [2:0] IDX_UNS  = 3'h0;
    localparam logic [15:0] OTP_PHR_MAX = 16'h0007;
    localparam int NPARAM = 6;
    localparam int NCMD   = 5;
    // array operations requested from the flash macro
    typedef enum logic [2:0] {
        OP_BLANK, OP_PROG, OP_ERASE_ALL, OP_ERASE_BLK, OP_ERASE_SEC
    } fepo_op_e;
    // mode-mask bit of a command code, NCMD when unknown
    function automatic logic [2:0] fepo_slot(input logic [7:0] code);
        unique case (code)
            CMD_OTP:  fepo_slot = 3'h0;
            CMD_EALL: fepo_slot = 3'h1;
            CMD_EBLK: fepo_slot = 3'h2;
            CMD_ESEC: fepo_slot = 3'h3;
            CMD_UNS:  fepo_slot = 3'h4;
            default:  fepo_slot = 3'h5;
        endcase
    endfunction
endpackage

// [shared/fepo_chk_if.sv]
// interface: launch-time check inputs and results
`timescale 1ns/1ps
interface fepo_chk_if;
    logic [7:0]  cmd;
    logic [2:0]  idx;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [4:0]  mode_mask;
    logic        addr_valid;
    logic        addr_is_dflash;
    logic        prot_any;
    logic        prot_block;
    logic        prot_sector;
    logic        acc_err;
    logic        pviol;
    modport seq (output cmd, idx, word0, word1, mode_mask, addr_valid,
                 addr_is_dflash, prot_any, prot_block, prot_sector,
                 input acc_err, pviol);
    modport chk (input cmd, idx, word0, word1, mode_mask, addr_valid,
                 addr_is_dflash, prot_any, prot_block, prot_sector,
                 output acc_err, pviol);
endinterface

// [rtl/fepo_launch_chk.sv]
// launch-time parameter, mode and protection checks
`timescale 1ns/1ps
module fepo_launch_chk (
    fepo_chk_if.chk c
);
    import fepo_pkg::*;

    logic [2:0] slot;
    logic       mode_ok;
    logic       phr_mis;

    // mode table lives outside, so availability is a mask input
    assign slot    = fepo_slot(c.cmd);
    assign mode_ok = (slot < 3'h5) && c.mode_mask[slot];
    assign phr_mis = (c.word1[2:0] != 3'h0);

    // error decode per command; both flags may be raised together
    always_comb begin
        c.acc_err = 1'b1;
        c.pviol   = 1'b0;
        unique case (c.cmd)
            CMD_OTP: begin
                c.acc_err = !mode_ok || (c.idx != IDX_OTP)
                          || (c.word1 > OTP_PHR_MAX);
            end
            CMD_EALL, CMD_UNS: begin
                c.acc_err = !mode_ok || (c.idx != IDX_EALL);
                c.pviol   = c.prot_any;
            end
            CMD_EBLK: begin
                c.acc_err = !mode_ok || (c.idx != IDX_EBLK)
                          || !c.addr_valid
                          || (c.addr_is_dflash ? c.word1[0] : phr_mis);
                c.pviol   = c.prot_block;
            end
            CMD_ESEC: begin
                c.acc_err = !mode_ok || (c.idx != IDX_ESEC) || !c.addr_valid
                          || c.addr_is_dflash || phr_mis;
                c.pviol   = c.prot_sector;
            end
            default: begin
                c.acc_err = 1'b1;
            end
        endcase
    end
endmodule

// [dv/fepo_seq_tb.sv]
// testbench for the flash command sequencer, driving apb and the array side
`timescale 1ns/1ps
module fepo_seq_tb;
    import fepo_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  mode_mask = 5'h1f;
    logic        addr_valid = 1'b1;
    logic        addr_is_dflash = 1'b0;
    logic        prot_any = 1'b0;
    logic        prot_block = 1'b0;
    logic        prot_sector = 1'b0;
    logic [22:0] tgt_addr;
    logic        array_req;
    fepo_op_e    array_op;
    logic [22:0] array_addr;
    logic [63:0] array_wdata;
    logic        array_ack = 1'b0;
    logic        array_blank = 1'b1;
    logic        array_verr = 1'b0;
    logic        array_vfatal = 1'b0;
    logic        blk0_read_invalid;
    logic        sec_release;
    logic [31:0] rdv;
    logic        errv;
    fepo_op_e    last_op;
    logic [22:0] last_addr;
    logic [63:0] last_wd;
    logic        last_inv;
    int          n_fail = 0;
    int          checked = 0;
    int          n_ack = 0;
    int          n_sec = 0;
    int          wcnt = 0;
    int          cyc = 0;

    fepo_seq #(.AW(23)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_mask(mode_mask),
        .addr_valid(addr_valid), .addr_is_dflash(addr_is_dflash), .prot_any(prot_any),
        .prot_block(prot_block), .prot_sector(prot_sector), .tgt_addr(tgt_addr),
        .array_req(array_req), .array_op(array_op), .array_addr(array_addr),
        .array_wdata(array_wdata), .array_ack(array_ack), .array_blank(array_blank),
        .array_verr(array_verr), .array_vfatal(array_vfatal),
        .blk0_read_invalid(blk0_read_invalid), .sec_release(sec_release)
    );

    always #2.5 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // array side answers after three request cycles, slower than the sequencer
    always @(posedge pclk) begin
        if (array_ack === 1'b1) begin
            n_ack++;
            last_op = array_op;
            last_addr = array_addr;
            last_wd = array_wdata;
            last_inv = blk0_read_invalid;
            array_ack <= 1'b0;
        end else if (array_req === 1'b1 && wcnt == 2) begin
            array_ack <= 1'b1;
            wcnt = 0;
        end else if (array_req === 1'b1) begin
            wcnt++;
        end
        if (sec_release === 1'b1) begin
            n_sec++;
        end
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // a slave that never answers is ended by the cycle ceiling
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] st(input logic a, input logic p, input logic v,
                                      input logic x);
        st = STAT_RST;
        st[STAT_ACC] = a;
        st[STAT_PV] = p;
        st[STAT_VF] = v;
        st[STAT_VX] = x;
    endfunction

    // load all six params, set the index, launch and wait for completion
    task automatic cmd(input logic [7:0] code, input logic [6:0] hi, input logic [15:0] p1,
                       input logic [2:0] li, input logic [7:0] exp, input int nack,
                       input fepo_op_e op);
        int k;
        logic [15:0] pv [6];
        pv = '{{code, 1'b0, hi}, p1, 16'ha5a5, 16'h0f0f, 16'h1234, 16'hfedc};
        for (k = 0; k < NPARAM; k++) begin
            apb(1'b1, ADDR_IDX, k);
            apb(1'b1, ADDR_DATA, {16'h0, pv[k]});
        end
        apb(1'b1, ADDR_IDX, {29'h0, li});
        n_ack = 0;
        n_sec = 0;
        apb(1'b1, ADDR_STAT, 32'h80);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(rdv[STAT_CMPL], 1'b0);
        k = 0;
        while (rdv[STAT_CMPL] !== 1'b1 && k < 50) begin
            apb(1'b0, ADDR_STAT, 32'h0);
            k++;
        end
        check(rdv[7:0], exp);
        check(n_ack, nack);
        if (nack > 0) begin
            check(last_op, op);
        end
        check(blk0_read_invalid, 1'b0);
    endtask

    task automatic t_reset();
        apb(1'b0, ADDR_STAT, 32'h0);
        check(rdv, {24'h0, STAT_RST});
        apb(1'b0, 8'h0c, 32'h0);
        check(errv, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_otp();
        cmd(CMD_OTP, 7'h0, 16'h0003, IDX_OTP, st(0, 0, 0, 0), 2, OP_PROG);
        check(last_addr, 23'h3);
        check(last_wd, 64'ha5a5_0f0f_1234_fedc);
        check(last_inv, 1'b1);
        array_verr <= 1'b1;
        array_vfatal <= 1'b1;
        cmd(CMD_OTP, 7'h0, OTP_PHR_MAX, IDX_OTP, st(0, 0, 1, 1), 2, OP_PROG);
        array_verr <= 1'b0;
        array_vfatal <= 1'b0;
        array_blank <= 1'b0;
        cmd(CMD_OTP, 7'h0, 16'h0003, IDX_OTP, st(1, 0, 0, 0), 1, OP_BLANK);
        array_blank <= 1'b1;
        cmd(CMD_OTP, 7'h0, 16'h0003, 3'h4, st(1, 0, 0, 0), 0, OP_BLANK);
        cmd(CMD_OTP, 7'h0, 16'h0008, IDX_OTP, st(1, 0, 0, 0), 0, OP_BLANK);
        $display("test one-time program done");
    endtask

    // each command refused once when its mode bit is cleared
    task automatic t_mode();
        logic [7:0] cd [5] = '{CMD_OTP, CMD_EALL, CMD_EBLK, CMD_ESEC, CMD_UNS};
        logic [2:0] ix [5] = '{IDX_OTP, IDX_EALL, IDX_EBLK, IDX_ESEC, IDX_UNS};
        for (int i = 0; i < NCMD; i++) begin
            mode_mask <= 5'h1f ^ (5'h01 << i);
            cmd(cd[i], 7'h0, 16'h0, ix[i], st(1, 0, 0, 0), 0, OP_BLANK);
        end
        mode_mask <= 5'h1f;
        $display("test mode mask done");
    endtask

    // erase-all and unsecure share checks and the security release
    task automatic t_eall();
        logic [7:0] cd [2] = '{CMD_EALL, CMD_UNS};
        for (int i = 0; i < 2; i++) begin
            prot_any <= 1'b1;
            cmd(cd[i], 7'h0, 16'h0, IDX_EALL, st(0, 1, 0, 0), 0, OP_BLANK);
            prot_any <= 1'b0;
            cmd(cd[i], 7'h0, 16'h0, 3'h1, st(1, 0, 0, 0), 0, OP_BLANK);
            cmd(cd[i], 7'h0, 16'h0, IDX_UNS, st(0, 0, 0, 0), 1, OP_ERASE_ALL);
            check(n_sec, 1);
            array_verr <= 1'b1;
            cmd(cd[i], 7'h0, 16'h0, IDX_UNS, st(0, 0, 1, 0), 1, OP_ERASE_ALL);
            check(n_sec, 0);
            array_verr <= 1'b0;
        end
        $display("test erase all and unsecure done");
    endtask

    task automatic t_blk();
        cmd(CMD_EBLK, 7'h12, 16'h3450, IDX_EBLK, st(0, 0, 0, 0), 1, OP_ERASE_BLK);
        check(last_addr, 23'h12_3450);
        check(tgt_addr, 23'h12_3450);
        cmd(CMD_EBLK, 7'h12, 16'h3454, IDX_EBLK, st(1, 0, 0, 0), 0, OP_BLANK);
        cmd(CMD_EBLK, 7'h12, 16'h3450, 3'h0, st(1, 0, 0, 0), 0, OP_BLANK);
        addr_is_dflash <= 1'b1;
        cmd(CMD_EBLK, 7'h12, 16'h3452, IDX_EBLK, st(0, 0, 0, 0), 1, OP_ERASE_BLK);
        cmd(CMD_EBLK, 7'h12, 16'h3453, IDX_EBLK, st(1, 0, 0, 0), 0, OP_BLANK);
        addr_is_dflash <= 1'b0;
        addr_valid <= 1'b0;
        cmd(CMD_EBLK, 7'h7f, 16'h3450, IDX_EBLK, st(1, 0, 0, 0), 0, OP_BLANK);
        addr_valid <= 1'b1;
        prot_block <= 1'b1;
        cmd(CMD_EBLK, 7'h12, 16'h3450, IDX_EBLK, st(0, 1, 0, 0), 0, OP_BLANK);
        prot_block <= 1'b0;
        $display("test block erase done");
    endtask

    task automatic t_sec();
        cmd(CMD_ESEC, 7'h01, 16'h0238, IDX_ESEC, st(0, 0, 0, 0), 1, OP_ERASE_SEC);
        cmd(CMD_ESEC, 7'h01, 16'h0239, IDX_ESEC, st(1, 0, 0, 0), 0, OP_BLANK);
        prot_sector <= 1'b1;
        cmd(CMD_ESEC, 7'h01, 16'h0238, IDX_ESEC, st(0, 1, 0, 0), 0, OP_BLANK);
        prot_sector <= 1'b0;
        array_vfatal <= 1'b1;
        cmd(CMD_ESEC, 7'h01, 16'h0238, IDX_ESEC, st(0, 0, 0, 1), 1, OP_ERASE_SEC);
        array_vfatal <= 1'b0;
        $display("test sector erase done");
    endtask

    // clock enable low freezes the index; a mid-run reset restores defaults
    task automatic t_ce();
        apb(1'b1, ADDR_IDX, 32'h3);
        ce <= 1'b0;
        apb(1'b1, ADDR_IDX, 32'h5);
        ce <= 1'b1;
        apb(1'b0, ADDR_IDX, 32'h0);
        check(rdv, 32'h3);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_IDX, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(rdv, {24'h0, STAT_RST});
        $display("test clock enable and reset done");
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_otp();
        t_mode();
        t_eall();
        t_blk();
        t_sec();
        t_ce();
        conclude();
    end
endmodule
